/* File: atsp_pkg.sv */
// shared constants for the translated-traffic and page request handler
package atsp_pkg;
    localparam logic [1:0] ATS_MODE_OFF   = 2'h0;
    localparam logic [1:0] ATS_MODE_FULL  = 2'h1;
    localparam logic [1:0] ATS_MODE_SPLIT = 2'h2;
    localparam int         RID_W          = 16;
    localparam int         ADDR_W         = 52;
    localparam int         PASID_W        = 20;
    localparam int         PQ_LOG2_MAX    = 4;
    localparam int         PQ_ENTRY_W     = 64;
    localparam logic       RST_LOW        = 1'b0;
endpackage

/* File: atsp_handler.sv */
// translated-traffic gate, translation completion builder and page request queue
`timescale 1ns/1ps
module atsp_handler
    import atsp_pkg::*;
#(
    parameter int SID_W       = 20,
    parameter bit ATS_SUPPORT = 1'b1,
    parameter bit PRI_SUPPORT = 1'b1,
    parameter bit SPLIT_CAP   = 1'b1,
    parameter bit OOR_ABORT   = 1'b0,
    parameter int PQ_MAX      = PQ_LOG2_MAX
) (
    input  wire logic                  mclk,
    input  wire logic                  rst,
    // configuration and capabilities
    input  wire logic                  translation_enable,
    input  wire logic                  translated_check_enable,
    input  wire logic                  hw_flag_update,
    input  wire logic [5:0]            output_addr_size,
    input  wire logic [3:0]            page_queue_log2,
    output logic                       split_stage_capability,
    output logic [3:0]                 page_queue_size_max,
    output logic                       ats_capability,
    output logic                       pri_capability,
    // translated transactions
    input  wire logic                  xl_valid,
    input  wire logic [SID_W-1:0]      xl_sid,
    input  wire logic                  xl_secure,
    input  wire logic [ADDR_W-1:0]     xl_addr,
    input  wire logic [1:0]            xl_endpoint_ats_mode,
    output logic                       xl_done,
    output logic                       xl_pass,
    output logic                       xl_abort,
    output logic                       xl_stage2,
    output logic [ADDR_W-1:0]          xl_addr_out,
    output logic                       translated_forbidden_event,
    output logic [SID_W-1:0]           xl_event_sid,
    // translation requests, walk result presented with the request
    input  wire logic                  tq_valid,
    input  wire logic [SID_W-1:0]      tq_sid,
    input  wire logic                  tq_secure,
    input  wire logic                  tq_pasid_valid,
    input  wire logic [PASID_W-1:0]    tq_pasid,
    input  wire logic                  tq_exec,
    input  wire logic                  tq_priv,
    input  wire logic                  tq_nw,
    input  wire logic [1:0]            tq_endpoint_ats_mode,
    output logic                       tq_ssv,
    output logic [PASID_W-1:0]         tq_ssid,
    output logic [RID_W-1:0]           tq_requester_id,
    output logic [SID_W-1:0]           tq_rc_select,
    input  wire logic                  walk_ok,
    input  wire logic                  walk_read,
    input  wire logic                  walk_write,
    input  wire logic                  walk_exec,
    input  wire logic                  walk_priv_only,
    input  wire logic                  walk_global,
    input  wire logic [ADDR_W-1:0]     walk_pa,
    input  wire logic [ADDR_W-1:0]     walk_ipa,
    output logic                       cpl_valid,
    output logic                       cpl_unsupported,
    output logic                       cpl_read,
    output logic                       cpl_write,
    output logic                       cpl_exec,
    output logic                       cpl_global,
    output logic [ADDR_W-1:0]          cpl_addr,
    output logic [SID_W-1:0]           cpl_sid,
    output logic                       flag_update_valid,
    output logic                       flag_update_dirty,
    output logic [ADDR_W-1:0]          flag_update_addr,
    // page requests
    input  wire logic                  page_request_msg,
    input  wire logic [PQ_ENTRY_W-1:0] page_request_data,
    input  wire logic [SID_W-1:0]      page_request_sid,
    output logic                       page_request_taken,
    output logic                       page_auto_response,
    output logic [SID_W-1:0]           page_auto_response_sid,
    output logic [PQ_MAX:0]            page_queue_prod,
    input  wire logic [PQ_MAX:0]       page_queue_cons,
    input  wire logic [PQ_MAX-1:0]     page_queue_rd_idx,
    output logic [PQ_ENTRY_W-1:0]      page_queue_rd_data
);
    localparam int PW = PQ_MAX + 1;

    typedef struct packed {
        logic                  xl_done;
        logic                  xl_pass;
        logic                  xl_abort;
        logic                  xl_stage2;
        logic [ADDR_W-1:0]     xl_addr;
        logic                  xl_event;
        logic [SID_W-1:0]      xl_sid;
        logic                  cpl_valid;
        logic                  cpl_ur;
        logic                  cpl_r;
        logic                  cpl_w;
        logic                  cpl_x;
        logic                  cpl_g;
        logic [ADDR_W-1:0]     cpl_addr;
        logic [SID_W-1:0]      cpl_sid;
        logic                  fu_valid;
        logic                  fu_dirty;
        logic [ADDR_W-1:0]     fu_addr;
        logic                  pr_taken;
        logic                  pr_auto;
        logic [SID_W-1:0]      pr_sid;
        logic [PW-1:0]         prod;
        logic [PQ_ENTRY_W-1:0] rd_data;
    } atsp_state_type;

    atsp_state_type s_q;
    atsp_state_type s_d;

    // entries carry no reset; only the producer index says what is valid
    logic [PQ_ENTRY_W-1:0] queue_mem [2**PQ_MAX];

    // pri without ats is never built
    localparam bit PRI_EN = PRI_SUPPORT && ATS_SUPPORT;

    logic [1:0]        xl_mode_eff;
    logic [1:0]        tq_mode_eff;
    logic              xl_forbid;
    logic [ADDR_W-1:0] oas_mask;
    logic              xl_oor;
    logic              tq_refuse;
    logic              g_r;
    logic              g_w;
    logic              g_x;
    logic              page_bad;
    logic              priv_fail;
    logic [3:0]        q_log2;
    logic [PW-1:0]     q_size;
    logic [PW-1:0]     q_used;
    logic              q_full;

    // split mode falls back to off without checking or split capability, so unchecked split traffic passes and skips stage 2
    always_comb begin
        // reserved code 3 is treated as full mode
        xl_mode_eff = xl_endpoint_ats_mode;
        if (xl_endpoint_ats_mode == ATS_MODE_SPLIT && (!translated_check_enable || !SPLIT_CAP)) begin
            xl_mode_eff = ATS_MODE_OFF;
        end
        tq_mode_eff = tq_endpoint_ats_mode;
        if (tq_endpoint_ats_mode == ATS_MODE_SPLIT && (!translated_check_enable || !SPLIT_CAP)) begin
            tq_mode_eff = ATS_MODE_OFF;
        end
    end

    assign xl_forbid = !translation_enable || xl_secure
                       || (translated_check_enable && xl_mode_eff == ATS_MODE_OFF);
    // shifts of 52 or more keep the whole address
    assign oas_mask  = ~({ADDR_W{1'b1}} << output_addr_size);
    assign xl_oor    = |(xl_addr & ~oas_mask);

    // secure and disabled streams get an unsupported answer, never an event
    assign tq_refuse = !ATS_SUPPORT || !translation_enable || tq_secure
                       || tq_mode_eff == ATS_MODE_OFF;
    // no pasid means data, unprivileged
    assign priv_fail = walk_priv_only && !(tq_pasid_valid && tq_priv);
    // completions cannot express these permission sets
    assign page_bad  = (walk_exec && !walk_read) || (walk_write && walk_exec);
    assign g_r       = walk_ok && !page_bad && !priv_fail && walk_read;
    assign g_w       = g_r && walk_write && !tq_nw;
    assign g_x       = g_r && walk_exec && tq_pasid_valid && tq_exec;

    assign q_log2 = (page_queue_log2 > 4'(PQ_MAX)) ? 4'(PQ_MAX) : page_queue_log2;
    assign q_size = PW'(1) << q_log2;
    // wrap bit tells a full queue from an empty one
    assign q_used = s_q.prod - page_queue_cons;
    assign q_full = q_used >= q_size;

    always_comb begin
        s_d          = s_q;
        s_d.xl_done  = 1'b0;
        s_d.xl_event = 1'b0;
        s_d.cpl_valid = 1'b0;
        s_d.fu_valid = 1'b0;
        s_d.pr_taken = 1'b0;
        s_d.pr_auto  = 1'b0;
        // read port registered: one cycle from index to data
        s_d.rd_data  = queue_mem[page_queue_rd_idx];
        if (xl_valid) begin
            s_d.xl_done   = 1'b1;
            s_d.xl_sid    = xl_sid;
            s_d.xl_stage2 = 1'b0;
            s_d.xl_addr   = xl_addr;
            if (xl_forbid) begin
                s_d.xl_pass  = 1'b0;
                s_d.xl_abort = 1'b1;
                s_d.xl_event = 1'b1;
            end else if (translated_check_enable && xl_mode_eff == ATS_MODE_SPLIT) begin
                // address is an ipa, stage 2 range checks apply downstream
                s_d.xl_pass   = 1'b1;
                s_d.xl_abort  = 1'b0;
                s_d.xl_stage2 = 1'b1;
            end else if (xl_oor && OOR_ABORT) begin
                s_d.xl_pass  = 1'b0;
                s_d.xl_abort = 1'b1;
            end else begin
                s_d.xl_pass  = 1'b1;
                s_d.xl_abort = 1'b0;
                s_d.xl_addr  = xl_addr & oas_mask;
            end
        end
        if (tq_valid) begin
            s_d.cpl_valid = 1'b1;
            s_d.cpl_sid   = tq_sid;
            s_d.cpl_ur    = tq_refuse;
            s_d.cpl_r     = !tq_refuse && g_r;
            s_d.cpl_w     = !tq_refuse && g_w;
            s_d.cpl_x     = !tq_refuse && g_x;
            // global kept on non-pasid answers even when refused
            s_d.cpl_g     = walk_global && !tq_pasid_valid;
            s_d.cpl_addr  = (tq_mode_eff == ATS_MODE_SPLIT) ? walk_ipa : walk_pa;
            if (!tq_refuse && hw_flag_update && g_r) begin
                s_d.fu_valid = 1'b1;
                s_d.fu_dirty = g_w;
                s_d.fu_addr  = s_d.cpl_addr;
            end
        end
        // a full queue never stalls the link; the sender is answered at once
        if (PRI_EN && page_request_msg) begin
            s_d.pr_sid = page_request_sid;
            if (q_full) begin
                s_d.pr_auto = 1'b1;
            end else begin
                s_d.pr_taken = 1'b1;
                s_d.prod     = s_q.prod + PW'(1);
            end
        end
        // synchronous reset last, so it overrides every branch above
        if (rst) begin
            s_d = '0;
        end
    end

    always_ff @(posedge mclk) begin
        s_q <= s_d;
    end

    // entry written at the producer slot before the index moves on
    always_ff @(posedge mclk) begin
        // same full test as the state update, so a refused entry is never written
        if (PRI_EN && !rst && page_request_msg && !q_full) begin
            queue_mem[s_q.prod[PQ_MAX-1:0]] <= page_request_data;
        end
    end

    assign split_stage_capability = SPLIT_CAP;
    assign page_queue_size_max    = 4'(PQ_MAX);
    assign ats_capability         = ATS_SUPPORT;
    assign pri_capability         = PRI_EN;

    assign tq_ssv          = tq_pasid_valid;
    assign tq_ssid         = tq_pasid_valid ? tq_pasid : '0;
    assign tq_requester_id = tq_sid[RID_W-1:0];
    assign tq_rc_select    = tq_sid >> RID_W;

    // pass and abort gated by done so neither stands between requests
    assign xl_done                    = s_q.xl_done;
    assign xl_pass                    = s_q.xl_pass && s_q.xl_done;
    assign xl_abort                   = s_q.xl_abort && s_q.xl_done;
    assign xl_stage2                  = s_q.xl_stage2;
    assign xl_addr_out                = s_q.xl_addr;
    assign translated_forbidden_event = s_q.xl_event;
    assign xl_event_sid               = s_q.xl_sid;
    assign cpl_valid                  = s_q.cpl_valid;
    assign cpl_unsupported            = s_q.cpl_ur;
    assign cpl_read                   = s_q.cpl_r;
    assign cpl_write                  = s_q.cpl_w;
    assign cpl_exec                   = s_q.cpl_x;
    assign cpl_global                 = s_q.cpl_g;
    assign cpl_addr                   = s_q.cpl_addr;
    assign cpl_sid                    = s_q.cpl_sid;
    assign flag_update_valid          = s_q.fu_valid;
    assign flag_update_dirty          = s_q.fu_dirty;
    assign flag_update_addr           = s_q.fu_addr;
    assign page_request_taken         = s_q.pr_taken;
    assign page_auto_response         = s_q.pr_auto;
    assign page_auto_response_sid     = s_q.pr_sid;
    assign page_queue_prod            = s_q.prod;
    assign page_queue_rd_data         = s_q.rd_data;
endmodule

/* File: atsp_handler_asserts.sv */
// concurrent checks on the handler's ports
`timescale 1ns/1ps
module atsp_handler_asserts
    import atsp_pkg::*;
#(
    parameter int SID_W  = 20,
    parameter int PQ_MAX = PQ_LOG2_MAX
) (
    input logic              mclk,
    input logic              rst,
    input logic              translation_enable,
    input logic              translated_check_enable,
    input logic              xl_valid,
    input logic              xl_secure,
    input logic [1:0]        xl_endpoint_ats_mode,
    input logic              xl_done,
    input logic              xl_pass,
    input logic              xl_abort,
    input logic              xl_stage2,
    input logic              translated_forbidden_event,
    input logic              tq_valid,
    input logic              tq_pasid_valid,
    input logic              tq_nw,
    input logic              cpl_valid,
    input logic              cpl_global,
    input logic              flag_update_valid,
    input logic              flag_update_dirty,
    input logic              page_request_msg,
    input logic              page_request_taken,
    input logic              page_auto_response,
    input logic [PQ_MAX:0]   page_queue_prod
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    logic ok;
    assign ok = xl_valid && translation_enable && !xl_secure;
    xl_answer_a: assert property (xl_valid |=> xl_done && (xl_pass != xl_abort))
        else $error("translated answer wrong");
    bypass_pass_a: assert property (ok && !translated_check_enable |=>
        xl_pass && !translated_forbidden_event) else $error("bypass not passed");
    mode_off_a: assert property (ok && translated_check_enable &&
        xl_endpoint_ats_mode == ATS_MODE_OFF |=> xl_abort && translated_forbidden_event)
        else $error("forbidden request not aborted");
    split_stage_a: assert property (ok && translated_check_enable &&
        xl_endpoint_ats_mode == ATS_MODE_SPLIT |=> xl_pass && xl_stage2)
        else $error("split request skipped stage 2");
    secure_abort_a: assert property (xl_valid && xl_secure |=>
        xl_abort && translated_forbidden_event) else $error("secure request not aborted");
    pasid_global_a: assert property (tq_valid && tq_pasid_valid |=>
        cpl_valid && !cpl_global) else $error("global set on pasid completion");
    nw_clean_a: assert property (tq_valid && tq_nw |=>
        !(flag_update_valid && flag_update_dirty)) else $error("dirty on read-only");
    no_tq_event_a: assert property (tq_valid && !xl_valid |=>
        !translated_forbidden_event) else $error("event for translation request");
    page_queue_a: assert property (page_request_msg |=>
        (page_request_taken && !page_auto_response &&
         page_queue_prod == $past(page_queue_prod) + 1'b1) ||
        (page_auto_response && !page_request_taken && $stable(page_queue_prod)))
        else $error("page request handling wrong");
endmodule
bind atsp_handler atsp_handler_asserts #(.SID_W(SID_W), .PQ_MAX(PQ_MAX))
    u_atsp_handler_asserts (.*);

/* File: atsp_rc_model.sv */
// root complex stand-in that forwards page requests
`timescale 1ns/1ps
module atsp_rc_model
    import atsp_pkg::*;
(
    input  logic                  mclk,
    input  logic                  retry_en,
    input  logic                  kick,
    input  logic [PQ_ENTRY_W-1:0] kick_data,
    input  logic                  cpl_valid,
    input  logic                  cpl_read,
    output logic                  page_request_msg,
    output logic [PQ_ENTRY_W-1:0] page_request_data
);
    // a refused read stands for not present, so the endpoint asks for the page
    always @(negedge mclk) begin
        page_request_msg  <= kick || (retry_en && cpl_valid && !cpl_read);
        page_request_data <= kick_data;
    end
endmodule

/* File: atsp_handler_tb.sv */
// self-checking bench: random traffic plus page queue corners
`timescale 1ns/1ps
module atsp_handler_tb;
    import atsp_pkg::*;
    localparam int SID_W  = 20;
    localparam int PQ_MAX = PQ_LOG2_MAX;
    logic               mclk, rst, translation_enable, translated_check_enable, hw_flag_update;
    logic               split_stage_capability, ats_capability, pri_capability, xl_valid;
    logic               xl_secure, xl_done, xl_pass, xl_abort, xl_stage2, tq_valid, tq_secure;
    logic               translated_forbidden_event, tq_pasid_valid, tq_exec, tq_priv, tq_nw;
    logic               tq_ssv, walk_ok, walk_read, walk_write, walk_exec, walk_priv_only;
    logic               walk_global, cpl_valid, cpl_unsupported, cpl_read, cpl_write, cpl_exec;
    logic               cpl_global, flag_update_valid, flag_update_dirty, page_request_msg;
    logic               page_request_taken, page_auto_response, retry_en, kick, pxl, ptq, full;
    logic [1:0]         xl_endpoint_ats_mode, tq_endpoint_ats_mode;
    logic [3:0]         page_queue_log2, page_queue_size_max, ex;
    logic [5:0]         output_addr_size;
    logic [6:0]         et;
    logic [SID_W-1:0]   xl_sid, xl_event_sid, tq_sid, tq_rc_select, cpl_sid, page_request_sid;
    logic [SID_W-1:0]   page_auto_response_sid, psid, tsid;
    logic [ADDR_W-1:0]  xl_addr, xl_addr_out, walk_pa, walk_ipa, cpl_addr, exa, eta;
    logic [ADDR_W-1:0]  flag_update_addr;
    logic [PASID_W-1:0] tq_pasid, tq_ssid;
    logic [RID_W-1:0]   tq_requester_id;
    logic [63:0]        page_request_data, kick_data, page_queue_rd_data, r, a;
    logic [63:0]        exp_mem [16];
    logic [PQ_MAX:0]    page_queue_prod, page_queue_cons, exp_prod, occ;
    logic [PQ_MAX-1:0]  page_queue_rd_idx;
    int                 seed, bad_count, num_checks, cl;

    atsp_handler #(.SID_W(SID_W)) u_atsp_handler (.*);
    atsp_rc_model u_atsp_rc_model (.*);

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic c1(input string n, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %b got %b", n, e, g);
        end
    endtask
    task automatic cv(input string n, input logic [63:0] e, input logic [63:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h got %h", n, e, g);
        end
    endtask
    // result order: pass, abort, event, stage2
    function automatic logic [3:0] xl_exp();
        logic [1:0] m;
        m = xl_endpoint_ats_mode;
        if (m == ATS_MODE_SPLIT && !translated_check_enable) m = ATS_MODE_OFF;
        if (!translation_enable || xl_secure || (translated_check_enable && m == ATS_MODE_OFF))
            return 4'b0110;
        return {3'b100, translated_check_enable && m == ATS_MODE_SPLIT};
    endfunction
    function automatic logic [6:0] tq_exp();
        logic u, rd, wr;
        u = !translation_enable || tq_secure || tq_endpoint_ats_mode == ATS_MODE_OFF ||
            (tq_endpoint_ats_mode == ATS_MODE_SPLIT && !translated_check_enable);
        rd = !u && walk_ok && walk_read && !(walk_exec && walk_write) &&
             !(walk_priv_only && !(tq_pasid_valid && tq_priv));
        wr = rd && walk_write && !tq_nw;
        return {u, rd, wr, rd && walk_exec && tq_pasid_valid && tq_exec,
                walk_global && !tq_pasid_valid, !u && hw_flag_update && rd, wr};
    endfunction
    task automatic check_prev();
        cv("rc_sel", tq_sid >> 16, tq_rc_select);
        cv("req_id", tq_sid[15:0], tq_requester_id);
        c1("ssv", tq_pasid_valid, tq_ssv);
        cv("ssid", tq_pasid_valid ? tq_pasid : 20'h0, tq_ssid);
        c1("xl_done", pxl, xl_done);
        c1("cpl_valid", ptq, cpl_valid);
        if (pxl) begin
            c1("xl_pass", ex[3], xl_pass);
            c1("xl_abort", ex[2], xl_abort);
            c1("forbidden", ex[1], translated_forbidden_event);
            if (ex[3]) c1("stage2", ex[0], xl_stage2);
            if (ex[3]) cv("xl_addr_out", exa, xl_addr_out);
            if (ex[1]) cv("event_sid", psid, xl_event_sid);
        end
        if (ptq) begin
            c1("unsupported", et[6], cpl_unsupported);
            c1("cpl_read", et[5], cpl_read);
            c1("cpl_write", et[4], cpl_write);
            c1("cpl_exec", et[3], cpl_exec);
            c1("cpl_global", et[2], cpl_global);
            c1("flag_valid", et[1], flag_update_valid);
            if (et[1]) c1("flag_dirty", et[0], flag_update_dirty);
            if (et[5]) cv("cpl_addr", eta, cpl_addr);
            if (et[1]) cv("flag_addr", eta, flag_update_addr);
            cv("cpl_sid", tsid, cpl_sid);
        end
    endtask
    // pending queue state is read before this edge's updates land
    always @(negedge mclk) begin
        if (!rst && page_request_msg) begin
            cl = (page_queue_log2 > 4'(PQ_MAX)) ? PQ_MAX : int'(page_queue_log2);
            occ = exp_prod - page_queue_cons;
            full = int'(occ) >= (1 << cl);
            c1("taken", !full, page_request_taken);
            c1("auto_resp", full, page_auto_response);
            if (full) cv("auto_sid", page_request_sid, page_auto_response_sid);
            if (!full) begin
                exp_mem[exp_prod[PQ_MAX-1:0]] = page_request_data;
                exp_prod = exp_prod + 1'b1;
            end
            cv("prod", exp_prod, page_queue_prod);
        end
    end
    // about ten times the planned run
    initial begin
        #20000;
        bad_count++;
        complete_run();
    end
    initial begin
        {seed, bad_count, num_checks, exp_prod, rst} = {32'd8, 64'd0, 5'd0, 1'b1};
        {translation_enable, translated_check_enable, hw_flag_update, xl_valid, xl_secure,
         tq_valid, tq_secure, tq_pasid_valid, tq_exec, tq_priv, tq_nw, walk_ok, walk_read,
         walk_write, walk_exec, walk_priv_only, walk_global, retry_en, kick, pxl, ptq} = '0;
        {xl_endpoint_ats_mode, tq_endpoint_ats_mode, output_addr_size, xl_sid, tq_sid, xl_addr,
         walk_pa, walk_ipa, tq_pasid, kick_data, page_queue_cons, page_queue_rd_idx} = '0;
        {page_queue_log2, page_request_sid} = {4'h2, 20'h0abcd};
        repeat (5) @(negedge mclk);
        rst = 1'b0;
        c1("pri_cap", 1'b1, pri_capability);
        c1("ats_cap", 1'b1, ats_capability);
        c1("split_cap", 1'b1, split_stage_capability);
        cv("size_max", 64'h4, page_queue_size_max);
        for (int i = 0; i < 9; i++) begin
            if (i == 6) page_queue_cons <= 5'h04;
            kick <= 1'b1;
            kick_data <= {$random(seed), $random(seed)};
            @(negedge mclk);
        end
        kick <= 1'b0;
        repeat (3) @(negedge mclk);
        for (int i = 0; i < 7; i++) begin
            page_queue_rd_idx <= 4'(i);
            @(negedge mclk);
            cv("rd_data", exp_mem[i], page_queue_rd_data);
        end
        page_queue_log2 <= 4'hf;
        retry_en <= 1'b1;
        for (int i = 0; i < 400; i++) begin
            @(negedge mclk);
            check_prev();
            r = {$random(seed), $random(seed)};
            a = {$random(seed), $random(seed)};
            translation_enable = |r[1:0];
            xl_secure = &r[3:2];
            tq_secure = &r[5:4];
            {translated_check_enable, hw_flag_update, tq_pasid_valid, tq_exec, tq_priv, tq_nw,
             walk_ok, walk_read, walk_write, walk_exec, walk_priv_only, walk_global,
             xl_endpoint_ats_mode, tq_endpoint_ats_mode, xl_valid, tq_valid} = r[23:6];
            output_addr_size = {1'b1, r[28:24]};
            {xl_sid, tq_sid, tq_pasid} = a[63:4];
            {xl_addr, walk_pa, walk_ipa} = {a[51:0], ~a[51:0], a[63:12]};
            ex = xl_exp();
            exa = (ex[0] || output_addr_size > 6'd51) ? xl_addr :
                  xl_addr & ((52'h1 << output_addr_size) - 52'h1);
            et = tq_exp();
            eta = (tq_endpoint_ats_mode == ATS_MODE_SPLIT && translated_check_enable) ?
                  walk_ipa : walk_pa;
            {pxl, ptq, psid, tsid} = {xl_valid, tq_valid, xl_sid, tq_sid};
        end
        @(negedge mclk);
        check_prev();
        {xl_valid, tq_valid} = 2'b00;
        repeat (4) @(negedge mclk);
        complete_run();
    end
endmodule
